/* pkg/cio_pkg.sv */
// Constants, field layout and types for the camera I/O line control block
// Overview of operation
// - In user output mode only the low three bits of the user value set line levels.
// - User value bit 2 drives line 3 and bit 0 drives line 1, so 4 sets line 3 high only.
// - Line 3 is general line B, line 2 is general line A, line 1 is the isolated output.
// - The counter trigger counts edges of the isolated input, general line A or B.
// - In counter trigger mode one trigger is issued per completed count of input edges.
// - A counter reset request drops the count in progress and starts counting afresh.
// - The pulse-width trigger takes its input from the isolated input, general line A or B.
// - While the serial port is enabled both general lines serve only the serial link.
// - The serial link runs at a chosen rate from 9600 to 115200 baud, equal on both ends.
// - A cable setting makes one general line the transmitter and the other the receiver.
// - A send request transmits the transmit value; an accept request captures received data.
// - The shutter mode selects rolling shutter or global reset operation.
// - Exposure-active selects a specified-line window or the common exposure time.
// - In specified-line mode exposure-active rises when readout reaches the start line.
// - In specified-line mode exposure-active falls when readout reaches the end line.
package cio_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_MIN = 9600;
  localparam int BAUD_MAX = 115200;
  localparam logic [15:0] BIT_CYC_RST = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] BIT_CYC_MIN = 16'(CLK_HZ / BAUD_MAX);
  localparam logic [15:0] BIT_CYC_MAX = 16'(CLK_HZ / BAUD_MIN);
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LINE = 6'h04;
  localparam logic [5:0] OFS_USER = 6'h08;
  localparam logic [5:0] OFS_CNT = 6'h0C;
  localparam logic [5:0] OFS_CMD = 6'h10;
  localparam logic [5:0] OFS_TXD = 6'h14;
  localparam logic [5:0] OFS_RXD = 6'h18;
  localparam logic [5:0] OFS_BAUD = 6'h1C;
  localparam logic [5:0] OFS_XSTART = 6'h20;
  localparam logic [5:0] OFS_XEND = 6'h24;
  localparam logic [5:0] OFS_STAT = 6'h28;
  // Control register fields
  localparam int TSRC_LSB = 0;
  localparam int CSRC_LSB = 2;
  localparam int PSRC_LSB = 4;
  localparam int UART_EN_BIT = 6;
  localparam int CABLE_BIT = 7;
  localparam int SHUT_BIT = 8;
  localparam int XMODE_BIT = 9;
  localparam int CTRL_W = 10;
  // Line register fields: bits 2..0 user mode per line, 3 and 4 general line drive
  localparam int LINE_W = 5;
  localparam int GA_OE_BIT = 3;
  localparam int GB_OE_BIT = 4;
  // Command register bits
  localparam int CMD_CRST = 0;
  localparam int CMD_SEND = 1;
  localparam int CMD_ACCEPT = 2;
  // Status register fields
  localparam int STAT_XACT = 16;
  localparam int STAT_RXNEW = 17;
  localparam int STAT_BUSY = 18;
  // Selector codes
  localparam logic [1:0] SRC_ISO = 2'h0;
  localparam logic [1:0] SRC_GA = 2'h1;
  localparam logic [1:0] SRC_GB = 2'h2;
  localparam logic [1:0] TRIG_NONE = 2'h0;
  localparam logic [1:0] TRIG_CNT = 2'h1;
  localparam logic [1:0] TRIG_PWM = 2'h2;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [LINE_W-1:0] LINE_RST = 5'h00;
  localparam logic [15:0] CNT_VAL_RST = 16'h0001;
  localparam logic [11:0] XSTART_RST = 12'h000;
  localparam logic [11:0] XEND_RST = 12'h000;
  typedef enum logic [3:0] {
    CIO_IDLE = 4'h1,
    CIO_START = 4'h2,
    CIO_DATA = 4'h4,
    CIO_STOP = 4'h8
  } cio_ser_e;
endpackage : cio_pkg

/* hdl/cio_uart.sv */
// Serial transmitter and receiver for the general lines, 8 data bits, no parity
`timescale 1ns/1ps
module cio_uart import cio_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bit period in clock cycles
  input wire logic [15:0] bit_cyc,
  // Transmit side
  input wire logic send,
  input wire logic [7:0] tx_data,
  output logic tx_line,
  output logic busy,
  // Receive side
  input wire logic rx_line,
  output logic [7:0] rx_data,
  output logic rx_done
);
  cio_ser_e ts, next_ts, rs, next_rs;
  logic [15:0] tcnt, next_tcnt, rcnt, next_rcnt;
  logic [2:0] tbit, next_tbit, rbit, next_rbit;
  logic [7:0] tsh, next_tsh, rsh, next_rsh, next_rx_data;
  logic next_tx_line, next_rx_done;
  logic tend, rend, rhalf;

  assign tend = (tcnt == bit_cyc - 16'h0001);
  assign rend = (rcnt == bit_cyc - 16'h0001);
  assign rhalf = (rcnt == {1'b0, bit_cyc[15:1]});
  assign busy = (ts != CIO_IDLE);

  always_comb begin
    next_ts = ts;
    next_tcnt = tend ? 16'h0000 : tcnt + 16'h0001;
    next_tbit = tbit;
    next_tsh = tsh;
    next_tx_line = tx_line;
    case (ts)
      CIO_IDLE: begin
        next_tcnt = 16'h0000;
        next_tx_line = 1'b1;
        if (send) begin
          next_ts = CIO_START;
          next_tsh = tx_data;
          next_tx_line = 1'b0;
        end
      end
      CIO_START: if (tend) begin
        next_ts = CIO_DATA;
        next_tbit = 3'h0;
        next_tx_line = tsh[0];
      end
      CIO_DATA: if (tend) begin
        if (tbit == 3'h7) begin
          next_ts = CIO_STOP;
          next_tx_line = 1'b1;
        end else begin
          next_tbit = tbit + 3'h1;
          next_tsh = {1'b0, tsh[7:1]};
          next_tx_line = tsh[1];
        end
      end
      CIO_STOP: if (tend) next_ts = CIO_IDLE;
      default: begin
        next_ts = CIO_IDLE;
        next_tx_line = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_rs = rs;
    next_rcnt = rcnt + 16'h0001;
    next_rbit = rbit;
    next_rsh = rsh;
    next_rx_data = rx_data;
    next_rx_done = 1'b0;
    case (rs)
      CIO_IDLE: begin
        next_rcnt = 16'h0000;
        if (!rx_line) next_rs = CIO_START;
      end
      CIO_START: if (rhalf) begin
        next_rcnt = 16'h0000;
        next_rbit = 3'h0;
        next_rs = rx_line ? CIO_IDLE : CIO_DATA;
      end
      CIO_DATA: if (rend) begin
        next_rcnt = 16'h0000;
        next_rsh = {rx_line, rsh[7:1]};
        if (rbit == 3'h7) next_rs = CIO_STOP;
        else next_rbit = rbit + 3'h1;
      end
      CIO_STOP: if (rend) begin
        next_rs = CIO_IDLE;
        if (rx_line) begin
          next_rx_data = rsh;
          next_rx_done = 1'b1;
        end
      end
      default: next_rs = CIO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ts <= CIO_IDLE;
      tcnt <= 16'h0000;
      tbit <= 3'h0;
      tsh <= 8'h00;
      tx_line <= 1'b1;
      rs <= CIO_IDLE;
      rcnt <= 16'h0000;
      rbit <= 3'h0;
      rsh <= 8'h00;
      rx_data <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      ts <= next_ts;
      tcnt <= next_tcnt;
      tbit <= next_tbit;
      tsh <= next_tsh;
      tx_line <= next_tx_line;
      rs <= next_rs;
      rcnt <= next_rcnt;
      rbit <= next_rbit;
      rsh <= next_rsh;
      rx_data <= next_rx_data;
      rx_done <= next_rx_done;
    end
  end
endmodule : cio_uart

/* hdl/cio_line_ctrl.sv */
// Camera I/O line control: user outputs, counter and pulse-width triggers, serial link
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module cio_line_ctrl import cio_pkg::*; (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Line pins
  input wire logic ISO_IN,
  output logic ISO_OUT,
  input wire logic GEN_A_IN,
  output logic GEN_A_OUT,
  output logic GEN_A_OE,
  input wire logic GEN_B_IN,
  output logic GEN_B_OUT,
  output logic GEN_B_OE,
  // Sensor timing
  input wire logic [11:0] READ_ROW,
  input wire logic READ_ROW_VALID,
  input wire logic EXPO_COMMON,
  // Trigger and exposure outputs
  output logic TRIG_PULSE,
  output logic TRIG_WIDTH,
  output logic EXPO_ACTIVE,
  output logic SHUTTER_GLOBAL
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic sel_src(input logic [2:0] lines, input logic [1:0] s);
    logic r;
    case (s)
      SRC_ISO: r = lines[0];
      SRC_GA: r = lines[1];
      SRC_GB: r = lines[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sel_src

  // Register state
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [LINE_W-1:0] line_cfg, next_line_cfg;
  logic [31:0] user_val, next_user_val;
  logic [15:0] cnt_val, next_cnt_val, baud, next_baud;
  logic [7:0] tx_val, next_tx_val, rx_val, next_rx_val;
  logic [11:0] xstart, next_xstart, xend, next_xend;
  logic cnt_rst_p, next_cnt_rst_p, send_p, next_send_p, accept_p, next_accept_p;
  logic rx_new, next_rx_new;
  logic [31:0] next_rdata;
  logic next_wait;
  logic wr_en;
  // Input synchronisers, bit 0 isolated, 1 general A, 2 general B
  logic [2:0] s1, s2, s3, filt, next_filt;
  logic [2:0] avail;
  // Trigger state
  logic [15:0] count, next_count;
  logic cnt_prev, next_cnt_prev, cnt_sig, pwm_sig;
  logic next_trig_pulse, next_trig_width;
  logic xact, next_xact;
  // Serial link
  logic uart_tx, uart_busy, uart_rx_line, uart_done;
  logic [7:0] uart_rx_data;
  logic [15:0] bit_cyc;
  // Output next values
  logic [2:0] lv;
  logic next_iso, next_ga, next_ga_oe, next_gb, next_gb_oe;

  logic uart_en, cable_b_tx, cnt_mode;
  assign uart_en = ctrl[UART_EN_BIT];
  assign cable_b_tx = ctrl[CABLE_BIT];
  assign cnt_mode = (ctrl[TSRC_LSB +: 2] == TRIG_CNT);
  assign wr_en = AVS_WRITE && !AVS_WAITREQUEST;

  // Bus: one wait state, writes commit at the edge where waitrequest is low
  always_comb begin
    next_wait = 1'b1;
    next_rdata = AVS_READDATA;
    if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) next_wait = 1'b0;
    if (AVS_READ && AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        OFS_CTRL: next_rdata = 32'(ctrl);
        OFS_LINE: next_rdata = 32'(line_cfg);
        OFS_USER: next_rdata = user_val;
        OFS_CNT: next_rdata = 32'(cnt_val);
        OFS_TXD: next_rdata = 32'(tx_val);
        OFS_RXD: next_rdata = 32'(rx_val);
        OFS_BAUD: next_rdata = 32'(baud);
        OFS_XSTART: next_rdata = 32'(xstart);
        OFS_XEND: next_rdata = 32'(xend);
        OFS_STAT: begin
          next_rdata = 32'(count);
          next_rdata[STAT_XACT] = xact;
          next_rdata[STAT_RXNEW] = rx_new;
          next_rdata[STAT_BUSY] = uart_busy;
        end
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    next_line_cfg = line_cfg;
    next_user_val = user_val;
    next_cnt_val = cnt_val;
    next_tx_val = tx_val;
    next_baud = baud;
    next_xstart = xstart;
    next_xend = xend;
    next_rx_val = rx_val;
    next_cnt_rst_p = 1'b0;
    next_send_p = 1'b0;
    next_accept_p = 1'b0;
    if (wr_en) begin
      case (AVS_ADDRESS)
        OFS_CTRL: next_ctrl = CTRL_W'(merge(32'(ctrl), AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_LINE: next_line_cfg = LINE_W'(merge(32'(line_cfg), AVS_WRITEDATA,
                                                AVS_BYTEENABLE));
        OFS_USER: next_user_val = merge(user_val, AVS_WRITEDATA, AVS_BYTEENABLE);
        OFS_CNT: next_cnt_val = 16'(merge(32'(cnt_val), AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_TXD: next_tx_val = 8'(merge(32'(tx_val), AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_BAUD: next_baud = 16'(merge(32'(baud), AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_XSTART: next_xstart = 12'(merge(32'(xstart), AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_XEND: next_xend = 12'(merge(32'(xend), AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_CMD: if (AVS_BYTEENABLE[0]) begin
          next_cnt_rst_p = AVS_WRITEDATA[CMD_CRST];
          next_send_p = AVS_WRITEDATA[CMD_SEND];
          next_accept_p = AVS_WRITEDATA[CMD_ACCEPT];
        end
        default: next_ctrl = ctrl;
      endcase
    end
    if (accept_p) next_rx_val = uart_rx_data;
  end

  // Received-byte flag: a new byte in the accept cycle keeps the flag set
  always_comb begin
    next_rx_new = rx_new;
    if (accept_p) next_rx_new = 1'b0;
    if (uart_done) next_rx_new = 1'b1;
  end

  // Change counts once the second and third stages agree
  always_comb begin
    next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
  end

  // General lines are withheld from trigger inputs while the serial port owns them
  assign avail = {filt[2] & ~uart_en, filt[1] & ~uart_en, filt[0]};
  assign cnt_sig = sel_src(avail, ctrl[CSRC_LSB +: 2]);
  assign pwm_sig = sel_src(avail, ctrl[PSRC_LSB +: 2]);

  always_comb begin
    next_cnt_prev = cnt_sig;
    next_count = count;
    next_trig_pulse = 1'b0;
    if (cnt_rst_p || !cnt_mode) begin
      next_count = 16'h0000;
    end else if (cnt_sig && !cnt_prev) begin
      if (count + 16'h0001 >= cnt_val) begin
        next_count = 16'h0000;
        next_trig_pulse = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
    next_trig_width = (ctrl[TSRC_LSB +: 2] == TRIG_PWM) && pwm_sig;
  end

  always_comb begin
    next_xact = xact;
    if (ctrl[XMODE_BIT]) begin
      if (READ_ROW_VALID && READ_ROW == xend) next_xact = 1'b0;
      else if (READ_ROW_VALID && READ_ROW == xstart) next_xact = 1'b1;
    end else begin
      next_xact = EXPO_COMMON;
    end
  end

  // Line 1 isolated, line 2 general A, line 3 general B
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lv[i] = line_cfg[i] ? user_val[i] : xact;
    end
    next_iso = lv[0];
    next_ga = lv[1];
    next_ga_oe = line_cfg[GA_OE_BIT];
    next_gb = lv[2];
    next_gb_oe = line_cfg[GB_OE_BIT];
    if (uart_en) begin
      next_ga = cable_b_tx ? 1'b1 : uart_tx;
      next_ga_oe = !cable_b_tx;
      next_gb = cable_b_tx ? uart_tx : 1'b1;
      next_gb_oe = cable_b_tx;
    end
  end

  assign uart_rx_line = cable_b_tx ? filt[1] : filt[2];
  // Rate held inside the 9600..115200 baud span
  assign bit_cyc = (baud < BIT_CYC_MIN) ? BIT_CYC_MIN :
                   (baud > BIT_CYC_MAX) ? BIT_CYC_MAX : baud;

  cio_uart u_uart (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .bit_cyc(bit_cyc),
    .send(send_p && uart_en),
    .tx_data(tx_val),
    .tx_line(uart_tx),
    .busy(uart_busy),
    .rx_line(uart_rx_line || !uart_en),
    .rx_data(uart_rx_data),
    .rx_done(uart_done)
  );

  always_ff @(posedge SYS_CLK) begin
    s1 <= {GEN_B_IN, GEN_A_IN, ISO_IN};
    s2 <= s1;
    s3 <= s2;
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      ctrl <= CTRL_RST;
      line_cfg <= LINE_RST;
      user_val <= 32'h00000000;
      cnt_val <= CNT_VAL_RST;
      tx_val <= 8'h00;
      rx_val <= 8'h00;
      baud <= BIT_CYC_RST;
      xstart <= XSTART_RST;
      xend <= XEND_RST;
      cnt_rst_p <= 1'b0;
      send_p <= 1'b0;
      accept_p <= 1'b0;
      rx_new <= 1'b0;
      filt <= 3'h0;
      count <= 16'h0000;
      cnt_prev <= 1'b0;
      xact <= 1'b0;
      TRIG_PULSE <= 1'b0;
      TRIG_WIDTH <= 1'b0;
      EXPO_ACTIVE <= 1'b0;
      SHUTTER_GLOBAL <= 1'b0;
      ISO_OUT <= 1'b0;
      GEN_A_OUT <= 1'b0;
      GEN_A_OE <= 1'b0;
      GEN_B_OUT <= 1'b0;
      GEN_B_OE <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= next_wait;
      AVS_READDATA <= next_rdata;
      ctrl <= next_ctrl;
      line_cfg <= next_line_cfg;
      user_val <= next_user_val;
      cnt_val <= next_cnt_val;
      tx_val <= next_tx_val;
      rx_val <= next_rx_val;
      baud <= next_baud;
      xstart <= next_xstart;
      xend <= next_xend;
      cnt_rst_p <= next_cnt_rst_p;
      send_p <= next_send_p;
      accept_p <= next_accept_p;
      rx_new <= next_rx_new;
      filt <= next_filt;
      count <= next_count;
      cnt_prev <= next_cnt_prev;
      xact <= next_xact;
      TRIG_PULSE <= next_trig_pulse;
      TRIG_WIDTH <= next_trig_width;
      EXPO_ACTIVE <= next_xact;
      SHUTTER_GLOBAL <= ctrl[SHUT_BIT];
      ISO_OUT <= next_iso;
      GEN_A_OUT <= next_ga;
      GEN_A_OE <= next_ga_oe;
      GEN_B_OUT <= next_gb;
      GEN_B_OE <= next_gb_oe;
    end
  end
endmodule : cio_line_ctrl

/* test/cio_monitor.sv */
// Port-level checks for the camera I/O line control block
`timescale 1ns/1ps
module cio_monitor import cio_pkg::*; (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register bus
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  // Lines
  input wire logic ISO_OUT,
  input wire logic GEN_A_OE,
  input wire logic GEN_B_OE,
  // Sensor timing
  input wire logic [11:0] READ_ROW,
  input wire logic READ_ROW_VALID,
  input wire logic EXPO_COMMON,
  // Trigger and exposure
  input wire logic TRIG_PULSE,
  input wire logic EXPO_ACTIVE,
  input wire logic SHUTTER_GLOBAL
);
  logic [CTRL_W-1:0] ctrl;
  logic [LINE_W-1:0] line;
  logic user;
  logic [11:0] xs;
  logic [11:0] xe;
  logic [3:0] since;
  // Shadow of settings; since counts cycles after the last write
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl <= CTRL_RST;
      line <= LINE_RST;
      user <= 1'b0;
      xs <= XSTART_RST;
      xe <= XEND_RST;
      since <= 4'h0;
    end else begin
      since <= (since == 4'hF) ? since : since + 4'h1;
      if (AVS_WRITE && !AVS_WAITREQUEST) begin
        since <= 4'h0;
        case (AVS_ADDRESS)
          OFS_CTRL: ctrl <= AVS_WRITEDATA[CTRL_W-1:0];
          OFS_LINE: line <= AVS_WRITEDATA[LINE_W-1:0];
          OFS_USER: user <= AVS_WRITEDATA[0];
          OFS_XSTART: xs <= AVS_WRITEDATA[11:0];
          OFS_XEND: xe <= AVS_WRITEDATA[11:0];
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  sequence s_row(r);
    READ_ROW_VALID && READ_ROW == r && since > 3 && ctrl[XMODE_BIT];
  endsequence
  AST_BUS_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_ack)
    else $error("bus answer not after one wait cycle");
  AST_TRIG_ONE: assert property (TRIG_PULSE |=> !TRIG_PULSE)
    else $error("trigger pulse longer than one cycle");
  AST_TRIG_MODE: assert property (since > 3 && ctrl[1:0] != TRIG_CNT |-> !TRIG_PULSE)
    else $error("trigger pulse outside counter mode");
  AST_USER_ISO: assert property (since > 3 && line[0] |-> ISO_OUT == user)
    else $error("line 1 does not follow user bit 0");
  AST_SERIAL_OE: assert property (since > 3 && ctrl[UART_EN_BIT] |->
    GEN_A_OE == !ctrl[CABLE_BIT] && GEN_B_OE == ctrl[CABLE_BIT])
    else $error("serial line drive wrong");
  AST_SHUTTER: assert property (since > 2 |-> SHUTTER_GLOBAL == ctrl[SHUT_BIT])
    else $error("shutter mode output wrong");
  AST_COMMON: assert property (since > 3 && !ctrl[XMODE_BIT] |->
    EXPO_ACTIVE == $past(EXPO_COMMON))
    else $error("common exposure not followed");
  AST_XSTART: assert property (s_row(xs) ##0 READ_ROW != xe |-> ##2 EXPO_ACTIVE)
    else $error("exposure not raised at start row");
  AST_XEND: assert property (s_row(xe) |-> ##2 !EXPO_ACTIVE)
    else $error("exposure not dropped at end row");
endmodule : cio_monitor

bind cio_line_ctrl cio_monitor u_cio_monitor (.SYS_CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_WAITREQUEST, .ISO_OUT, .GEN_A_OE, .GEN_B_OE, .READ_ROW,
  .READ_ROW_VALID, .EXPO_COMMON, .TRIG_PULSE, .EXPO_ACTIVE, .SHUTTER_GLOBAL);

/* test/cio_ext_equip.sv */
// External equipment on the isolated and general lines
`timescale 1ns/1ps
module cio_ext_equip #(
  parameter int BIT_CYC = 1736
) (
  // Clock
  input wire logic clk,
  // Levels driven: general B, general A, isolated
  output logic [2:0] lines,
  // Cable level of general line A
  input wire logic gen_a_pin
);
  initial lines = 3'h0;
  // Pulses outlast the input synchronisers
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      @(posedge clk);
      lines <= lines | (3'h1 << sel);
      repeat (6) @(posedge clk);
      lines <= lines & ~(3'h1 << sel);
      repeat (6) @(posedge clk);
    end
  endtask : pulse
  task automatic set(input logic [2:0] v);
    @(posedge clk);
    lines <= v;
  endtask : set
  // One start, eight data bits LSB first, one stop, on line B
  task automatic put_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      lines <= {f[i], lines[1:0]};
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask : put_byte
  task automatic get_byte(output logic [7:0] b);
    while (gen_a_pin !== 1'b0) @(posedge clk);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = gen_a_pin;
    end
  endtask : get_byte
endmodule : cio_ext_equip

/* test/cio_line_ctrl_tb_top.sv */
// Register-driven bench for the camera I/O line control block
`timescale 1ns/1ps
module cio_line_ctrl_tb_top import cio_pkg::*;;
  logic SYS_CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [5:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0] AVS_BYTEENABLE;
  logic ISO_OUT, GEN_A_OUT, GEN_A_OE, GEN_B_OUT, GEN_B_OE;
  logic [11:0] READ_ROW;
  logic READ_ROW_VALID, EXPO_COMMON, TRIG_PULSE, TRIG_WIDTH, EXPO_ACTIVE, SHUTTER_GLOBAL;
  wire logic ISO_IN, GEN_A_IN, GEN_B_IN;
  logic [2:0] ext;
  logic [7:0] got;
  int num_errors = 0;
  int n_compared = 0;
  int trig_n = 0;
  int t0;
  logic [5:0] adr [9] = '{OFS_CTRL, OFS_LINE, OFS_USER, OFS_CNT, OFS_CMD, OFS_BAUD,
    OFS_XSTART, OFS_XEND, 6'h30};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h6C8, 32'h0, 32'h0, 32'h0};
  // Each general pin sees the block while it drives, else the equipment
  assign ISO_IN = ext[0];
  assign GEN_A_IN = GEN_A_OE ? GEN_A_OUT : ext[1];
  assign GEN_B_IN = GEN_B_OE ? GEN_B_OUT : ext[2];
  cio_line_ctrl u_cio_line_ctrl (.SYS_CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .ISO_IN, .ISO_OUT,
    .GEN_A_IN, .GEN_A_OUT, .GEN_A_OE, .GEN_B_IN, .GEN_B_OUT, .GEN_B_OE, .READ_ROW,
    .READ_ROW_VALID, .EXPO_COMMON, .TRIG_PULSE, .TRIG_WIDTH, .EXPO_ACTIVE, .SHUTTER_GLOBAL);
  cio_ext_equip #(.BIT_CYC(1736)) u_cio_ext_equip (.clk(SYS_CLK), .lines(ext),
    .gen_a_pin(GEN_A_IN));
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    if (TRIG_PULSE === 1'b1) trig_n <= trig_n + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : cyc
  task automatic results;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge SYS_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge SYS_CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rc
  task automatic row(input logic [11:0] r);
    cyc(4);
    READ_ROW <= r;
    READ_ROW_VALID <= 1'b1;
    cyc(1);
    READ_ROW_VALID <= 1'b0;
    cyc(4);
  endtask : row
  initial begin
    cyc(40000);
    num_errors++;
    results();
  end
  initial begin
    SYS_RST = 1'b1;
    AVS_ADDRESS = 6'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hF;
    READ_ROW = 12'h0;
    READ_ROW_VALID = 1'b0;
    EXPO_COMMON = 1'b0;
    cyc(16);
    SYS_RST <= 1'b0;
    for (int i = 0; i < 9; i++) rc(adr[i], rv[i]);
    wr(OFS_LINE, 32'h1F);
    for (int v = 0; v < 8; v++) begin
      wr(OFS_USER, 32'hFFFFFFF8 | 32'(v));
      cyc(3);
      chk({29'h0, GEN_B_OUT, GEN_A_OUT, ISO_OUT}, 32'(v));
    end
    wr(OFS_LINE, 32'h1A);
    cyc(3);
    chk({31'h0, ISO_OUT}, 32'h0);
    EXPO_COMMON <= 1'b1;
    cyc(6);
    chk({30'h0, ISO_OUT, EXPO_ACTIVE}, 32'h3);
    EXPO_COMMON <= 1'b0;
    wr(OFS_LINE, 32'h0);
    wr(OFS_CNT, 32'h3);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_CTRL, (32'(s) << CSRC_LSB) | 32'(TRIG_CNT));
      t0 = trig_n;
      u_cio_ext_equip.pulse((s + 1) % 3, 3);
      u_cio_ext_equip.pulse(s, 6);
      cyc(10);
      chk(32'(trig_n - t0), 32'h2);
    end
    t0 = trig_n;
    u_cio_ext_equip.pulse(2, 2);
    wr(OFS_CMD, 32'h1 << CMD_CRST);
    u_cio_ext_equip.pulse(2, 2);
    cyc(10);
    chk(32'(trig_n - t0), 32'h0);
    u_cio_ext_equip.pulse(2, 1);
    cyc(10);
    chk(32'(trig_n - t0), 32'h1);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_CTRL, (32'(s) << PSRC_LSB) | 32'(TRIG_PWM));
      u_cio_ext_equip.set(3'h7 ^ (3'h1 << s));
      cyc(8);
      chk({31'h0, TRIG_WIDTH}, 32'h0);
      u_cio_ext_equip.set(3'h1 << s);
      cyc(8);
      chk({31'h0, TRIG_WIDTH}, 32'h1);
    end
    wr(OFS_CTRL, 32'h300);
    wr(OFS_XSTART, 32'hA);
    wr(OFS_XEND, 32'h14);
    chk({31'h0, SHUTTER_GLOBAL}, 32'h1);
    row(12'hA);
    chk({31'h0, EXPO_ACTIVE}, 32'h1);
    row(12'hF);
    chk({31'h0, EXPO_ACTIVE}, 32'h1);
    row(12'h14);
    chk({31'h0, EXPO_ACTIVE}, 32'h0);
    wr(OFS_CTRL, 32'h0);
    cyc(3);
    chk({31'h0, SHUTTER_GLOBAL}, 32'h0);
    u_cio_ext_equip.set(3'h6);
    wr(OFS_CTRL, 32'h1 << UART_EN_BIT);
    cyc(3);
    chk({30'h0, GEN_A_OE, GEN_B_OE}, 32'h2);
    wr(OFS_TXD, 32'hA5);
    fork
      wr(OFS_CMD, 32'h1 << CMD_SEND);
      u_cio_ext_equip.put_byte(8'h3C);
      u_cio_ext_equip.get_byte(got);
    join
    chk({24'h0, got}, 32'hA5);
    cyc(10);
    bus(1'b0, OFS_STAT, 32'h0, q);
    chk({31'h0, q[STAT_RXNEW]}, 32'h1);
    wr(OFS_CMD, 32'h1 << CMD_ACCEPT);
    rc(OFS_RXD, 32'h3C);
    wr(OFS_CTRL, (32'h1 << UART_EN_BIT) | (32'h1 << CABLE_BIT));
    cyc(3);
    chk({30'h0, GEN_A_OE, GEN_B_OE}, 32'h1);
    results();
  end
endmodule : cio_line_ctrl_tb_top
